// File: rscl_cfg.svh
/*
  Constants for the reset source cause logger: register offsets, bit positions,
  reset values and timing counts.
  Assumes a 10 MHz instruction clock and a 32-bit AHB-Lite register bus.
*/
`ifndef RSCL_CFG_SVH
`define RSCL_CFG_SVH

`define RSCL_STATUS_OFFSET 12'h000
`define RSCL_SHADOW_OFFSET 12'h004
`define RSCL_ADDR_MASK 12'hFFC
`define RSCL_BIT_TRAP 15
`define RSCL_BIT_ILLEGAL 14
`define RSCL_BIT_MISMATCH 9
`define RSCL_BIT_PIN 7
`define RSCL_BIT_SOFT 6
`define RSCL_BIT_WDOG 4
`define RSCL_BIT_SLEEP 3
`define RSCL_BIT_IDLE 2
`define RSCL_BIT_BROWNOUT 1
`define RSCL_BIT_POWERON 0
`define RSCL_STATUS_MASK 16'hC2DF
`define RSCL_STATUS_RESET 16'h0001
`define RSCL_CLK_PERIOD_NS 100
`define RSCL_PIN_MIN_WIDTH_NS 300
`define RSCL_PIN_FILTER_CYCLES ((`RSCL_PIN_MIN_WIDTH_NS + `RSCL_CLK_PERIOD_NS - 1) / `RSCL_CLK_PERIOD_NS)
`define RSCL_ILLEGAL_OPCODE 8'h3F
`define RSCL_HARD_TRAP_MIN 4'hD
`define RSCL_HARD_TRAP_MAX 4'hF
`define RSCL_NUM_WREGS 15
`define RSCL_RELEASE_STAGES 2

`endif

// File: rscl_pkg.sv
/*
  Types for the reset source cause logger.
  Assumes rscl_cfg.svh is included alongside.
*/
package rscl_pkg;
  typedef logic [15:0] rscl_status_t;
  typedef enum logic [1:0] {RSCL_RUN, RSCL_SOFT_HOLD, RSCL_SOFT_RELEASE} rscl_state_t;
endpackage : rscl_pkg

// File: rscl_reset_cause_logger.sv
/*
  Reset source cause logger: merges all reset requests into system_reset and keeps the
  reset_cause_status register, reachable over AHB-Lite.
  Assumes core event inputs are synchronous one-cycle strobes on ref_clk; por_n and
  brownout_reset come from analog supervisors; rstn is the cold reset of this logic.
*/
// Register access over AHB-Lite and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "rscl_cfg.svh"

module rscl_reset_cause_logger (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic por_n,
  input wire logic brownout_reset,
  input wire logic ext_reset_pin_n,
  input wire logic reset_instr,
  input wire logic watchdog_timeout,
  input wire logic sleep_mode,
  input wire logic idle_mode,
  input wire logic power_save_sleep_instr,
  input wire logic power_save_idle_instr,
  input wire logic watchdog_clear_instr,
  input wire logic trap_taken,
  input wire logic [3:0] trap_level,
  input wire logic [3:0] trap_active_level,
  input wire logic trap_in_service,
  input wire logic [15:0] pin_select_cfg,
  input wire logic opcode_valid,
  input wire logic [7:0] opcode_upper,
  input wire logic wreg_write,
  input wire logic [3:0] wreg_write_index,
  input wire logic addr_ptr_use,
  input wire logic [3:0] addr_ptr_index,
  input wire logic program_flow_change,
  input wire logic vector_flow_change,
  input wire logic flow_target_restricted,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic system_reset,
  output logic cold_reset,
  output logic clock_reinit,
  output logic watchdog_wake,
  output logic [23:0] reset_pc,
  output logic [14:0] wreg_initialized
);
  import rscl_pkg::*;

  rscl_status_t reset_cause_status;
  rscl_state_t soft_state;
  logic [15:0] pin_select_shadow;
  logic [3:0] pin_low_count;
  logic pin_reset_req;
  logic wd_reset_req;
  logic trap_conflict;
  logic config_mismatch;
  logic illegal_opcode;
  logic uninit_use;
  logic security_fault;
  logic warm_req;
  logic [`RSCL_RELEASE_STAGES-1:0] release_sync;
  logic wr_pend;
  logic [11:0] wr_addr;
  logic bus_take;
  logic [15:0] next_status;
  logic rd_take;
  logic sw_status_write;
  logic sw_shadow_write;
  logic set_pin;
  logic set_soft;
  logic set_wdog;
  logic set_trap;
  logic set_mismatch;
  logic set_illegal;
  logic set_sleep;
  logic set_idle;
  logic clr_wdog;

  // True when a trap level falls in the hard trap band
  function automatic logic rscl_is_hard(input logic [3:0] lvl);
    rscl_is_hard = (lvl >= `RSCL_HARD_TRAP_MIN) && (lvl <= `RSCL_HARD_TRAP_MAX);
  endfunction : rscl_is_hard

  // Word-aligned match of a bus address against a register offset
  function automatic logic rscl_addr_hit(input logic [11:0] addr, input logic [11:0] offset);
    rscl_addr_hit = ((addr & `RSCL_ADDR_MASK) == offset);
  endfunction : rscl_addr_hit

  // Glitch filter: pin must stay low for the full count before reset is asked
  // A pulse shorter than the count leaves no trace, since the count restarts at high
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pin_low_count <= 4'h0;
    end
    else if (ext_reset_pin_n)
    begin
      pin_low_count <= 4'h0;
    end
    else if (pin_low_count != 4'(`RSCL_PIN_FILTER_CYCLES))
    begin
      pin_low_count <= pin_low_count + 4'h1;
    end
  end
  assign pin_reset_req = (pin_low_count == 4'(`RSCL_PIN_FILTER_CYCLES));

  // Watchdog splits into reset in run and a wake-up in power save
  assign wd_reset_req = watchdog_timeout && !sleep_mode && !idle_mode;
  assign watchdog_wake = watchdog_timeout && (sleep_mode || idle_mode);

  // Hard trap conflict: lower hard trap while a higher one is serviced
  assign trap_conflict = trap_taken && trap_in_service && rscl_is_hard(trap_level)
    && (trap_level < trap_active_level);

  // Shadow copy of pin-select setup, loaded only by a bus write
  assign config_mismatch = (pin_select_cfg != pin_select_shadow);

  // Illegal conditions from decode and code protection
  assign illegal_opcode = opcode_valid && (opcode_upper == `RSCL_ILLEGAL_OPCODE);
  // The stack pointer is outside the tracked set, so index 15 never faults
  assign uninit_use = addr_ptr_use && (addr_ptr_index != 4'hF)
    && !wreg_initialized[addr_ptr_index];
  assign security_fault = (program_flow_change || vector_flow_change) && flow_target_restricted;

  // Soft reset holds one instruction cycle, then release
  // The release state swallows a repeated instruction until the reset has taken
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      soft_state <= RSCL_RUN;
    end
    else
    begin
      case (soft_state)
        RSCL_RUN:
        begin
          if (reset_instr)
          begin
            soft_state <= RSCL_SOFT_HOLD;
          end
        end
        RSCL_SOFT_HOLD:
        begin
          soft_state <= RSCL_SOFT_RELEASE;
        end
        RSCL_SOFT_RELEASE:
        begin
          soft_state <= RSCL_RUN;
        end
        default:
        begin
          soft_state <= RSCL_RUN;
        end
      endcase
    end
  end

  // Status register writes never feed these requests; shadow writes can, via config_mismatch
  assign warm_req = pin_reset_req || wd_reset_req || trap_conflict || config_mismatch
    || illegal_opcode || uninit_use || security_fault || (soft_state == RSCL_SOFT_HOLD);

  // Release stretched and synchronized; asynchronous assert covers watchdog
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      release_sync <= '1;
    end
    else if (warm_req)
    begin
      release_sync <= '1;
    end
    else
    begin
      release_sync <= {release_sync[`RSCL_RELEASE_STAGES-2:0], 1'b0};
    end
  end
  assign system_reset = !por_n || brownout_reset || wd_reset_req
    || release_sync[`RSCL_RELEASE_STAGES-1];
  assign cold_reset = !por_n || brownout_reset;
  // Only cold resets restart the oscillator; warm ones keep the current source
  assign clock_reinit = cold_reset;

  // Program counter vector held at zero under any reset
  // Fetch logic restarts from this value once system_reset falls
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      reset_pc <= 24'h000000;
    end
    else if (system_reset)
    begin
      reset_pc <= 24'h000000;
    end
    else
    begin
      reset_pc <= reset_pc;
    end
  end

  // Working register initialized marks, cleared by every reset
  // The stack pointer keeps no mark, as it is never cleared
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wreg_initialized <= 15'h0000;
    end
    else if (system_reset)
    begin
      wreg_initialized <= 15'h0000;
    end
    else if (wreg_write && (wreg_write_index != 4'hF))
    begin
      wreg_initialized[wreg_write_index] <= 1'b1;
    end
  end

  // AHB-Lite slave: zero wait state, writes land in the data phase
  assign bus_take = hsel && hready && htrans[1];
  assign rd_take = bus_take && !hwrite;
  assign hreadyout = 1'b1;
  // Every transfer completes, so the response is always OKAY
  assign hresp = 1'b0;

  // Address phase of a word write is kept for the following data phase
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wr_pend <= 1'b0;
      wr_addr <= 12'h000;
    end
    else if (hready)
    begin
      wr_pend <= bus_take && hwrite && (hsize == 3'h2);
      wr_addr <= haddr[11:0];
    end
  end
  assign sw_status_write = wr_pend && rscl_addr_hit(wr_addr, `RSCL_STATUS_OFFSET);
  assign sw_shadow_write = wr_pend && rscl_addr_hit(wr_addr, `RSCL_SHADOW_OFFSET);

  // Read data registered in the address phase; unmapped reads as zero
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      hrdata <= 32'h00000000;
    end
    else if (rd_take)
    begin
      if (rscl_addr_hit(haddr[11:0], `RSCL_STATUS_OFFSET))
      begin
        hrdata <= {16'h0000, reset_cause_status};
      end
      else if (rscl_addr_hit(haddr[11:0], `RSCL_SHADOW_OFFSET))
      begin
        hrdata <= {16'h0000, pin_select_shadow};
      end
      else
      begin
        hrdata <= 32'h00000000;
      end
    end
  end

  // Shadow loads from software only, so a disturbed pin-select copy stands out
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pin_select_shadow <= 16'h0000;
    end
    else if (sw_shadow_write)
    begin
      pin_select_shadow <= hwdata[15:0];
    end
  end

  // Flag set events, one per flag but brown-out and power-on, and one clear event for the watchdog flag
  assign set_pin = pin_reset_req;
  assign set_soft = (soft_state == RSCL_SOFT_HOLD);
  assign set_wdog = watchdog_timeout;
  assign set_trap = trap_conflict;
  assign set_mismatch = config_mismatch;
  assign set_illegal = illegal_opcode || uninit_use || security_fault;
  assign set_sleep = power_save_sleep_instr;
  assign set_idle = power_save_idle_instr;
  assign clr_wdog = power_save_sleep_instr || power_save_idle_instr || watchdog_clear_instr;

  // Status: software write first, then clears, then hardware sets win
  // A cause that fires while software clears its flag must not be lost
  always_comb
  begin
    next_status = reset_cause_status;
    if (sw_status_write)
    begin
      next_status = hwdata[15:0] & `RSCL_STATUS_MASK;
    end
    if (clr_wdog)
    begin
      next_status[`RSCL_BIT_WDOG] = 1'b0;
    end
    if (set_pin)
    begin
      next_status[`RSCL_BIT_PIN] = 1'b1;
    end
    if (set_soft)
    begin
      next_status[`RSCL_BIT_SOFT] = 1'b1;
    end
    if (set_wdog)
    begin
      next_status[`RSCL_BIT_WDOG] = 1'b1;
    end
    if (set_trap)
    begin
      next_status[`RSCL_BIT_TRAP] = 1'b1;
    end
    if (set_mismatch)
    begin
      next_status[`RSCL_BIT_MISMATCH] = 1'b1;
    end
    if (set_illegal)
    begin
      next_status[`RSCL_BIT_ILLEGAL] = 1'b1;
    end
    if (set_sleep)
    begin
      next_status[`RSCL_BIT_SLEEP] = 1'b1;
    end
    if (set_idle)
    begin
      next_status[`RSCL_BIT_IDLE] = 1'b1;
    end
  end

  // Cold resets clear flags; brown-out keeps the pin and power-on flags, power-on clears the pin flag
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      reset_cause_status <= `RSCL_STATUS_RESET;
    end
    else if (!por_n)
    begin
      reset_cause_status <= `RSCL_STATUS_RESET;
    end
    else if (brownout_reset)
    begin
      reset_cause_status <= (reset_cause_status & 16'h0081) | 16'h0002;
    end
    else
    begin
      reset_cause_status <= next_status;
    end
  end

endmodule : rscl_reset_cause_logger

// File: rscl_supervisor.sv
/*
  Model of the board supervisor that drives the active-low reset pin.
  Assumes the bench calls hold_low just after a rising clock edge.
*/
`timescale 1ns/1ps
module rscl_supervisor (
  input wire logic ref_clk,
  output logic ext_reset_pin_n
);
  // Pin rests high, as if pulled to supply between pulses
  initial ext_reset_pin_n = 1'b1;
  // Hold the pin low for n clock edges; short counts act as glitches
  task automatic hold_low(input int n);
    @(posedge ref_clk);
    ext_reset_pin_n <= 1'b0;
    repeat (n) @(posedge ref_clk);
    ext_reset_pin_n <= 1'b1;
  endtask : hold_low
endmodule : rscl_supervisor

// File: rscl_reset_cause_logger_assertions.sv
/*
  Checker on the ports of the reset cause logger.
  Assumes one clock domain, ref_clk, with rstn as its reset.
*/
`timescale 1ns/1ps
`include "rscl_cfg.svh"
module rscl_checker (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic por_n,
  input wire logic brownout_reset,
  input wire logic ext_reset_pin_n,
  input wire logic reset_instr,
  input wire logic watchdog_timeout,
  input wire logic sleep_mode,
  input wire logic idle_mode,
  input wire logic trap_taken,
  input wire logic [3:0] trap_level,
  input wire logic [3:0] trap_active_level,
  input wire logic trap_in_service,
  input wire logic opcode_valid,
  input wire logic [7:0] opcode_upper,
  input wire logic addr_ptr_use,
  input wire logic [3:0] addr_ptr_index,
  input wire logic program_flow_change,
  input wire logic vector_flow_change,
  input wire logic flow_target_restricted,
  input wire logic system_reset,
  input wire logic clock_reinit,
  input wire logic watchdog_wake,
  input wire logic [23:0] reset_pc,
  input wire logic [14:0] wreg_initialized
);
  // All checks share the one clock and its reset
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  wdog_run_reset_a: assert property (watchdog_timeout && !sleep_mode && !idle_mode |-> system_reset)
    else $error("watchdog time-out in run gave no reset");
  wdog_sleep_wake_a: assert property (watchdog_timeout && (sleep_mode || idle_mode) |-> watchdog_wake)
    else $error("watchdog time-out in sleep gave no wake");
  soft_reset_a: assert property (reset_instr && por_n && !brownout_reset |-> !clock_reinit ##2 system_reset)
    else $error("reset instruction handled wrongly");
  pin_filter_a: assert property (!ext_reset_pin_n [*3] |-> ##[0:4] system_reset)
    else $error("long pin pulse gave no reset");
  trap_conflict_a: assert property (trap_taken && trap_in_service && trap_level >= `RSCL_HARD_TRAP_MIN
    && trap_level < trap_active_level |-> ##[0:2] system_reset) else $error("trap conflict gave no reset");
  illegal_op_a: assert property (opcode_valid && opcode_upper == `RSCL_ILLEGAL_OPCODE |-> ##[0:2] system_reset)
    else $error("illegal opcode gave no reset");
  uninit_ptr_a: assert property (addr_ptr_use && addr_ptr_index < 4'hF
    && !wreg_initialized[addr_ptr_index] |-> ##[0:2] system_reset) else $error("uninitialized pointer gave no reset");
  secure_flow_a: assert property ((program_flow_change || vector_flow_change)
    && flow_target_restricted |-> ##[0:2] system_reset) else $error("restricted flow change gave no reset");
  release_sync_a: assert property ($rose(rstn) |-> system_reset)
    else $error("system reset released with rstn");
  pc_zero_a: assert property (reset_pc == 24'h000000)
    else $error("reset program counter not zero");
endmodule : rscl_checker

bind rscl_reset_cause_logger rscl_checker chk_u (.*);

// File: reset_source_cause_logger_bench.sv
/*
  Bench for the reset cause logger: bus tasks, one task per scenario, verdict.
  Assumes the design, its checker and the supervisor model.
*/
`timescale 1ns/1ps
`include "rscl_cfg.svh"
module reset_source_cause_logger_bench;
  import rscl_pkg::*;
  logic ref_clk, rstn, por_n, brownout_reset, ext_reset_pin_n, reset_instr, watchdog_timeout, sleep_mode;
  logic idle_mode, power_save_sleep_instr, power_save_idle_instr, watchdog_clear_instr, trap_taken;
  logic trap_in_service, opcode_valid, wreg_write, addr_ptr_use, program_flow_change, vector_flow_change;
  logic flow_target_restricted, hsel, hwrite, hready, hreadyout, hresp, system_reset, cold_reset;
  logic clock_reinit, watchdog_wake;
  logic [3:0] trap_level, trap_active_level, wreg_write_index, addr_ptr_index;
  logic [15:0] pin_select_cfg;
  logic [7:0] opcode_upper;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [23:0] reset_pc;
  logic [14:0] wreg_initialized;
  int err_total, check_count;
  rscl_reset_cause_logger dut_u (.*);
  rscl_supervisor sup_u (.ref_clk(ref_clk), .ext_reset_pin_n(ext_reset_pin_n));
  // Single slave, so its ready is the bus ready
  assign hready = hreadyout;
  // 10 MHz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // One word transfer; called just after a rising edge, read data lands in rd
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    hsize <= 3'h2;
    do @(posedge ref_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge ref_clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
      begin
        err_total++;
        $display("Error at %0t: saw %h expected %h", $time, got, exp);
      end
  endtask : chk
  // Let any reset stretch end, then read the cause register
  task automatic st(input logic [15:0] exp);
    repeat (6) @(posedge ref_clk);
    bus(1'b0, 32'h0, 32'h0);
    chk(rd[15:0], exp);
  endtask : st
  task automatic t_cold_pin;
    st(16'h0001);
    sup_u.hold_low(2);
    st(16'h0001);
    sup_u.hold_low(3);
    st(16'h0081);
    bus(1'b1, 32'h0, 32'hFFFF);
    chk({15'h0, system_reset}, 16'h0000);
    chk({14'h0, hresp, hreadyout}, 16'h0001);
    st(16'hC2DF);
    brownout_reset <= 1'b1;
    @(negedge ref_clk);
    chk({13'h0, cold_reset, clock_reinit, system_reset}, 16'h0007);
    @(posedge ref_clk);
    brownout_reset <= 1'b0;
    st(16'h0083);
    por_n <= 1'b0;
    @(posedge ref_clk);
    por_n <= 1'b1;
    st(16'h0001);
    bus(1'b0, 32'h8, 32'h0);
    chk(rd[15:0], 16'h0000);
  endtask : t_cold_pin
  // Each warm source but the pin sets its flag after the register is cleared
  task automatic t_events;
    logic [15:0] exp [8] = '{16'h0040, 16'h0010, 16'h8000, 16'h4000, 16'h4000, 16'h4000, 16'h4000, 16'h0200};
    for (int i = 0; i < 8; i++)
      begin
        bus(1'b1, 32'h0, 32'h0);
        case (i)
          0: reset_instr <= 1'b1;
          1: watchdog_timeout <= 1'b1;
          2: {trap_taken, trap_in_service, trap_level, trap_active_level} <= {2'b11, 4'hD, 4'hE};
          3: {opcode_valid, opcode_upper} <= {1'b1, 8'h3F};
          4: {program_flow_change, flow_target_restricted} <= 2'b11;
          5: {vector_flow_change, flow_target_restricted} <= 2'b11;
          6: {addr_ptr_use, addr_ptr_index} <= {1'b1, 4'h2};
          default: pin_select_cfg <= 16'h0001;
        endcase
        @(posedge ref_clk);
        {reset_instr, watchdog_timeout, trap_taken, opcode_valid, addr_ptr_use} <= '0;
        {program_flow_change, vector_flow_change, flow_target_restricted} <= '0;
        pin_select_cfg <= 16'h0000;
        st(exp[i]);
      end
  endtask : t_events
  task automatic t_power_save;
    sleep_mode <= 1'b1;
    bus(1'b1, 32'h0, 32'h0010);
    watchdog_timeout <= 1'b1;
    @(negedge ref_clk);
    chk({14'h0, watchdog_wake, system_reset}, 16'h0002);
    @(posedge ref_clk);
    {watchdog_timeout, power_save_sleep_instr} <= 2'b01;
    @(posedge ref_clk);
    {sleep_mode, power_save_sleep_instr} <= 2'b00;
    st(16'h0008);
    bus(1'b1, 32'h0, 32'h0010);
    watchdog_clear_instr <= 1'b1;
    @(posedge ref_clk);
    {watchdog_clear_instr, power_save_idle_instr} <= 2'b01;
    @(posedge ref_clk);
    power_save_idle_instr <= 1'b0;
    st(16'h0004);
  endtask : t_power_save
  // Written registers may serve as pointers; a soft reset clears the marks
  task automatic t_wreg;
    bus(1'b1, 32'h0, 32'h0);
    {wreg_write, wreg_write_index} <= {1'b1, 4'h2};
    @(posedge ref_clk);
    {wreg_write, addr_ptr_use, addr_ptr_index} <= {1'b0, 1'b1, 4'h2};
    @(posedge ref_clk);
    addr_ptr_use <= 1'b0;
    chk({1'b0, wreg_initialized}, 16'h0004);
    st(16'h0000);
    reset_instr <= 1'b1;
    @(posedge ref_clk);
    reset_instr <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk({1'b0, wreg_initialized}, 16'h0000);
  endtask : t_wreg
  task automatic end_sim;
    $display("Checks %0d, errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  // A hang counts as a mismatch; the whole run needs far fewer cycles
  initial
  begin
    #1000000;
    err_total++;
    end_sim;
  end
  initial
  begin
    {rstn, brownout_reset, reset_instr, watchdog_timeout, sleep_mode, idle_mode, power_save_sleep_instr} = '0;
    {power_save_idle_instr, watchdog_clear_instr, trap_taken, trap_in_service, opcode_valid, wreg_write} = '0;
    {addr_ptr_use, program_flow_change, vector_flow_change, flow_target_restricted, hsel, hwrite} = '0;
    {trap_level, trap_active_level, wreg_write_index, addr_ptr_index, pin_select_cfg, opcode_upper} = '0;
    {haddr, hwdata, htrans, hsize} = '0;
    por_n = 1'b1;
    err_total = 0;
    check_count = 0;
    repeat (3) @(posedge ref_clk);
    rstn <= 1'b1;
    t_cold_pin;
    t_events;
    t_power_save;
    t_wreg;
    end_sim;
  end
endmodule : reset_source_cause_logger_bench
